// [core/wcg_pkg.sv]
// package: constants shared by the write clock count guard
package wcg_pkg;
    // ************************************************************
    // frame layout, pulse counts include the start bit
    // ************************************************************
    localparam int unsigned WORD_W        = 16;
    localparam int unsigned ADDR_W        = 8;
    localparam int unsigned PAGE_WORDS    = 4;
    localparam int unsigned CNT_W         = 7;
    localparam logic [6:0]  CNT_MAX       = 7'h7f;
    localparam logic [6:0]  POS_OP_LAST   = 7'h03;
    localparam logic [6:0]  POS_ADDR_LAST = 7'h0b;
    localparam logic [6:0]  CNT_WRITE     = 7'h1b;  // 27
    localparam logic [6:0]  CNT_PAGE_MAX  = 7'h4b;  // 75
    localparam logic [6:0]  CNT_PROT_WR   = 7'h13;  // 19
    localparam logic [6:0]  CNT_PROT_CLR  = 7'h0b;  // 11
    // ************************************************************
    // opcodes and extended selectors in the upper address bits
    // ************************************************************
    localparam logic [1:0]  OP_EXT        = 2'h0;
    localparam logic [1:0]  OP_WRITE      = 2'h1;
    localparam logic [1:0]  OP_PAGE_WRITE = 2'h3;
    localparam logic [1:0]  EXT_FILL_ALL  = 2'h1;
    localparam logic [1:0]  EXT_PROT_WR   = 2'h2;
    localparam logic [1:0]  EXT_PROT_CLR  = 2'h3;
    // ************************************************************
    // reset values and timing
    // ************************************************************
    localparam logic [15:0] ERASED_WORD   = 16'hffff;
    localparam logic [7:0]  BOUND_CLEAR   = 8'hff;
    localparam int unsigned CLK_MHZ       = 10;
    localparam int unsigned PROG_TIME_US  = 5000;
    localparam int unsigned PROG_CYCLES   = PROG_TIME_US * CLK_MHZ;
    localparam int unsigned TIMER_W       = 20;
endpackage

// [core/wcg_pin_sync.sv]
// module: three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none
module wcg_pin_sync #(
    parameter int unsigned W = 3
) (
    // clock and control
    input  wire logic         mclk,
    input  wire logic         rst,
    input  wire logic         ce,
    // pins and filtered levels
    input  wire logic [W-1:0] pinIn,
    output logic      [W-1:0] level
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] lvl;
    } wcg_sync_t;

    wcg_sync_t st_q;
    wcg_sync_t st_d;

    always_comb begin
        st_d    = st_q;
        st_d.s1 = pinIn;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        for (int i = 0; i < int'(W); i++) begin
            // a change counts only once the last two stages agree
            if (st_q.s2[i] == st_q.s3[i]) begin
                st_d.lvl[i] = st_q.s3[i];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            st_q <= '0;
        end else if (ce) begin
            st_q <= st_d;
        end
    end

    assign level = st_q.lvl;
endmodule
`default_nettype wire

// [core/wcg_guard.sv]
// module: serial word memory with clock pulse count guard on writes
`timescale 1ns/1ns
`default_nettype none
module wcg_guard
    import wcg_pkg::*;
#(
    parameter int unsigned NWORDS      = 1 << wcg_pkg::ADDR_W,
    parameter int unsigned PROG_CYCLES = wcg_pkg::PROG_CYCLES
) (
    // clock, reset, enable
    input  wire logic                       mclk,
    input  wire logic                       rst,
    input  wire logic                       ce,
    // serial link pins
    input  wire logic                       selPin,
    input  wire logic                       sclkPin,
    input  wire logic                       dinPin,
    output logic                            dout,
    output logic                            doutOeN,
    // array observation port
    input  wire logic [wcg_pkg::ADDR_W-1:0] peekAddr,
    output logic [wcg_pkg::WORD_W-1:0]      peekData,
    output logic                            busy
);
    import wcg_pkg::*;

    typedef enum logic [1:0] {
        WCG_IDLE  = 2'b00,
        WCG_FRAME = 2'b01,
        WCG_PROG  = 2'b11,
        WCG_READY = 2'b10
    } wcg_state_t;

    typedef struct packed {
        wcg_state_t                              fsm;
        logic                                    sclkPrev;
        logic                                    selPrev;
        logic [CNT_W-1:0]                        cnt;
        logic [1:0]                              op;
        logic [ADDR_W-1:0]                       addr;
        logic [WORD_W-1:0]                       shift;
        logic [PAGE_WORDS-1:0][WORD_W-1:0]       page;
        logic [TIMER_W-1:0]                      timer;
        logic                                    protOn;
        logic [ADDR_W-1:0]                       bound;
        logic [NWORDS-1:0][WORD_W-1:0]           mem;
        logic                                    dout;
        logic                                    oeN;
        logic [WORD_W-1:0]                       peek;
        logic                                    busy;
    } wcg_core_t;

    wcg_core_t st_q;
    wcg_core_t st_d;
    logic [2:0] pinLvl;
    logic       selS;
    logic       sclkS;
    logic       dinS;

    wcg_pin_sync #(.W(3)) u_sync (
        .mclk  (mclk),
        .rst   (rst),
        .ce    (ce),
        .pinIn ({selPin, sclkPin, dinPin}),
        .level (pinLvl)
    );
    assign {selS, sclkS, dinS} = pinLvl;

    // number of data words held in a page frame of the given length
    function automatic logic [2:0] page_words(input logic [CNT_W-1:0] c);
        logic [CNT_W-1:0] d;
        d = c - POS_ADDR_LAST;
        page_words = d[6:4];
    endfunction

    // true when the pulse total fits the decoded instruction
    function automatic logic count_ok(input logic [1:0] op,
                                      input logic [ADDR_W-1:0] a,
                                      input logic [CNT_W-1:0] c);
        logic [CNT_W-1:0] d;
        d = c - POS_ADDR_LAST;
        count_ok = 1'b0;
        if (op == OP_WRITE) begin
            count_ok = (c == CNT_WRITE);
        end else if (op == OP_PAGE_WRITE) begin
            // select must fall right after a word boundary
            count_ok = (c >= CNT_WRITE) && (c <= CNT_PAGE_MAX)
                       && (d[3:0] == 4'h0);
        end else if (op != OP_EXT) begin
            // the remaining opcode is not a programming instruction
            count_ok = 1'b0;
        end else if (a[ADDR_W-1 -: 2] == EXT_FILL_ALL) begin
            count_ok = (c == CNT_WRITE);
        end else if (a[ADDR_W-1 -: 2] == EXT_PROT_WR) begin
            count_ok = (c == CNT_PROT_WR);
        end else if (a[ADDR_W-1 -: 2] == EXT_PROT_CLR) begin
            count_ok = (c == CNT_PROT_CLR);
        end
    endfunction

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        logic             rise;
        logic             selFall;
        logic [CNT_W-1:0] c;
        logic [2:0]       n;
        logic [ADDR_W-1:0] wa;
        logic             blocked;
        logic [1:0]       ext;
        rise    = 1'b0;
        selFall = 1'b0;
        c       = '0;
        n       = '0;
        wa      = '0;
        blocked = 1'b0;
        ext     = '0;
        st_d          = st_q;
        st_d.sclkPrev = sclkS;
        st_d.selPrev  = selS;
        rise    = sclkS && !st_q.sclkPrev;
        selFall = st_q.selPrev && !selS;
        ext     = st_q.addr[ADDR_W-1 -: 2];
        case (st_q.fsm)
            WCG_IDLE, WCG_READY: begin
                if (!selS) begin
                    st_d.cnt = '0;
                    st_d.fsm = WCG_IDLE;
                end else if (rise && dinS) begin
                    // start bit decoded: count it as the first pulse
                    st_d.cnt = 7'h01;
                    st_d.fsm = WCG_FRAME;
                end
            end
            WCG_FRAME: begin
                if (!selS) begin
                    st_d.cnt = '0;
                    st_d.fsm = WCG_IDLE;
                    if (selFall
                        && count_ok(st_q.op, st_q.addr, st_q.cnt)) begin
                        st_d.fsm   = WCG_PROG;
                        st_d.timer = TIMER_W'(PROG_CYCLES);
                        n = page_words(st_q.cnt);
                        if (st_q.op == OP_WRITE) begin
                            n = 3'h1;
                        end
                        if (st_q.op != OP_EXT) begin
                            for (int i = 0; i < int'(PAGE_WORDS); i++) begin
                                wa = {st_q.addr[ADDR_W-1:2],
                                      2'(st_q.addr[1:0] + 2'(i))};
                                if (i < int'(n) && st_q.protOn
                                    && wa >= st_q.bound) begin
                                    blocked = 1'b1;
                                end
                            end
                            for (int i = 0; i < int'(PAGE_WORDS); i++) begin
                                // only the two low bits advance
                                wa = {st_q.addr[ADDR_W-1:2],
                                      2'(st_q.addr[1:0] + 2'(i))};
                                if (!blocked && i < int'(n)) begin
                                    st_d.mem[wa] = st_q.page[i];
                                end
                            end
                        end else if (ext == EXT_FILL_ALL) begin
                            if (!st_q.protOn) begin
                                for (int j = 0; j < int'(NWORDS); j++) begin
                                    st_d.mem[j] = st_q.page[0];
                                end
                            end
                        end else if (ext == EXT_PROT_WR) begin
                            st_d.bound  = st_q.shift[ADDR_W-1:0];
                            st_d.protOn = 1'b1;
                        end else begin
                            st_d.bound  = BOUND_CLEAR;
                            st_d.protOn = 1'b0;
                        end
                    end
                end else if (rise) begin
                    // each edge is one bit, glitch or not
                    c = (st_q.cnt == CNT_MAX) ? CNT_MAX : st_q.cnt + 7'h01;
                    st_d.cnt = c;
                    if (c <= POS_OP_LAST) begin
                        st_d.op = {st_q.op[0], dinS};
                    end else if (c <= POS_ADDR_LAST) begin
                        st_d.addr = {st_q.addr[ADDR_W-2:0], dinS};
                    end else begin
                        st_d.shift = {st_q.shift[WORD_W-2:0], dinS};
                        n = page_words(c);
                        if (c[3:0] == POS_ADDR_LAST[3:0] && n != 3'h0
                            && n <= 3'(PAGE_WORDS)) begin
                            st_d.page[n - 3'h1] = st_d.shift;
                        end
                    end
                end
            end
            WCG_PROG: begin
                // frames are ignored while the cell array is busy
                st_d.cnt = '0;
                if (st_q.timer <= TIMER_W'(1)) begin
                    st_d.timer = '0;
                    st_d.fsm   = WCG_READY;
                end else begin
                    st_d.timer = st_q.timer - TIMER_W'(1);
                end
            end
            default: begin
                st_d.fsm = WCG_IDLE;
            end
        endcase
        // ready/busy on the output while selected
        st_d.dout = (st_d.fsm == WCG_READY);
        st_d.oeN  = !(selS && (st_d.fsm == WCG_PROG
                               || st_d.fsm == WCG_READY));
        st_d.peek = st_q.mem[peekAddr];
        st_d.busy = (st_d.fsm == WCG_PROG);
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            st_q        <= '0;
            st_q.fsm    <= WCG_IDLE;
            st_q.oeN    <= 1'b1;
            st_q.bound  <= BOUND_CLEAR;
            st_q.mem    <= {NWORDS{ERASED_WORD}};
            st_q.peek   <= ERASED_WORD;
        end else if (ce) begin
            st_q <= st_d;
        end
    end

    assign dout     = st_q.dout;
    assign doutOeN  = st_q.oeN;
    assign peekData = st_q.peek;
    assign busy     = st_q.busy;
endmodule
`default_nettype wire

// [verif/wcg_guard_chk.sv]
// checker: port-level assertions for the write clock count guard
`timescale 1ns/1ns
`default_nettype none
module wcg_guard_chk
    import wcg_pkg::*;
#(
    parameter int unsigned PROG_CYCLES = 20
) (
    // clock and control
    input wire logic              mclk,
    input wire logic              rst,
    input wire logic              ce,
    // serial link pins
    input wire logic              selPin,
    input wire logic              sclkPin,
    input wire logic              dinPin,
    input wire logic              dout,
    input wire logic              doutOeN,
    // array observation
    input wire logic [ADDR_W-1:0] peekAddr,
    input wire logic [WORD_W-1:0] peekData,
    input wire logic              busy
);
    int unsigned busyCnt_q;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // ************************************************************
    // programming cycle length and status pin
    // ************************************************************
    // counts busy cycles so the full length is checked without a repeat
    always_ff @(posedge mclk) begin
        busyCnt_q <= busy ? busyCnt_q + 1 : 0;
    end
    busy_len_a: assert property (
        $fell(busy) |-> busyCnt_q == PROG_CYCLES)
        else $error("programming cycle length wrong");
    busy_cap_a: assert property (
        busy |-> busyCnt_q < PROG_CYCLES)
        else $error("programming cycle overran");
    busy_low_a: assert property (
        busy && $past(busy) && !doutOeN |-> !dout)
        else $error("busy not shown low");
    ready_high_a: assert property (
        !doutOeN && !busy && !$past(busy) |-> dout)
        else $error("ready not shown high");
    oe_sel_a: assert property (
        !doutOeN |-> $past(selPin, 3) || $past(selPin, 4)
        || $past(selPin, 5) || $past(selPin, 6))
        else $error("output driven while not selected");
    commit_sel_a: assert property (
        $rose(busy) |-> !selPin && !$past(selPin, 2))
        else $error("programming started without select fall");
    hold_busy_a: assert property (
        busy && $past(busy) && $stable(peekAddr) |=> $stable(peekData))
        else $error("array changed during programming");
    reset_val_a: assert property (
        $past(rst) |-> !busy && doutOeN && peekData == ERASED_WORD)
        else $error("reset state wrong");
endmodule
bind wcg_guard wcg_guard_chk #(.PROG_CYCLES(PROG_CYCLES)) u_chk (.mclk(mclk),
    .rst(rst), .ce(ce), .selPin(selPin), .sclkPin(sclkPin), .dinPin(dinPin),
    .dout(dout), .doutOeN(doutOeN), .peekAddr(peekAddr), .peekData(peekData),
    .busy(busy));
`default_nettype wire

// [verif/wcg_master.sv]
// partner: serial bus master model that frames bits onto the link
`timescale 1ns/1ns
`default_nettype none
module wcg_master (
    // system clock
    input  wire logic mclk,
    // link pins towards the guard
    output logic      selPin,
    output logic      sclkPin,
    output logic      dinPin
);
    // half of the 800 ns link clock period, in mclk cycles
    localparam int HALF = 4;
    initial begin
        selPin = 1'b0;
        sclkPin = 1'b0;
        dinPin = 1'b0;
    end
    task automatic hold(input logic on);
        @(posedge mclk);
        selPin <= on;
    endtask
    // link clock stands still outside frames
    task automatic send(input logic [127:0] bits, input int n);
        @(posedge mclk);
        selPin <= 1'b1;
        repeat (HALF) @(posedge mclk);
        for (int i = n - 1; i >= 0; i--) begin
            sclkPin <= 1'b0;
            dinPin <= bits[i];
            repeat (HALF) @(posedge mclk);
            sclkPin <= 1'b1;
            repeat (HALF) @(posedge mclk);
        end
        sclkPin <= 1'b0;
        repeat (HALF) @(posedge mclk);
        selPin <= 1'b0;
        // data line inverted once select falls, so no stale level is left on it
        dinPin <= ~dinPin;
        repeat (2 * HALF) @(posedge mclk);
    endtask
endmodule
`default_nettype wire

// [verif/wcg_guard_tb.sv]
// testbench: frames through the bus master model, checks the array
`timescale 1ns/1ns
`default_nettype none
module wcg_guard_tb;
    import wcg_pkg::*;
    localparam int PROG = 400;
    logic              mclk, rst, ce, selPin, sclkPin, dinPin;
    logic              dout, doutOeN, busy;
    logic [ADDR_W-1:0] peekAddr;
    logic [WORD_W-1:0] peekData;
    int                failures, cmpCount, cycles;
    wcg_guard #(.NWORDS(256), .PROG_CYCLES(PROG)) DUT (.mclk(mclk), .rst(rst),
        .ce(ce), .selPin(selPin), .sclkPin(sclkPin), .dinPin(dinPin),
        .dout(dout), .doutOeN(doutOeN), .peekAddr(peekAddr),
        .peekData(peekData), .busy(busy));
    wcg_master u_master (.mclk(mclk), .selPin(selPin), .sclkPin(sclkPin),
        .dinPin(dinPin));
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles = cycles + 1;
        if (cycles == 40000) begin
            failures = failures + 1;
            stop_test();
        end
    end
    // ************************************************************
    // helpers
    // ************************************************************
    task automatic stop_test();
        if (failures == 0 && cmpCount > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        cmpCount++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chkBit(input logic got, input logic exp);
        cmpCount++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic peek(input logic [7:0] a, input logic [15:0] exp);
        @(posedge mclk);
        peekAddr <= a;
        repeat (3) @(negedge mclk);
        chk16(peekData, exp);
    endtask
    task automatic waitBusy(input logic lvl, input int lim);
        for (int i = 0; i < lim && busy !== lvl; i++) @(negedge mclk);
    endtask
    // expBusy below zero leaves the busy phase unchecked
    task automatic frame(input logic [127:0] b, input int n, input int expBusy);
        u_master.send(b, n);
        waitBusy(1'b1, 20);
        if (expBusy >= 0) chkBit(busy, expBusy[0]);
        waitBusy(1'b0, PROG + 20);
    endtask
    function automatic logic [127:0] wr(input logic [7:0] a,
                                        input logic [15:0] d);
        return {101'h0, 1'b1, OP_WRITE, a, d};
    endfunction
    function automatic logic [127:0] fill(input logic [15:0] d);
        return {101'h0, 1'b1, OP_EXT, EXT_FILL_ALL, 6'h00, d};
    endfunction
    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic s_status();
        u_master.send(wr(8'h12, 16'ha5c3), 27);
        waitBusy(1'b1, 20);
        u_master.hold(1'b1);
        repeat (8) @(negedge mclk);
        chkBit(doutOeN, 1'b0);
        chkBit(dout, 1'b0);
        waitBusy(1'b0, PROG + 20);
        repeat (3) @(negedge mclk);
        chkBit(dout, 1'b1);
        u_master.hold(1'b0);
        repeat (8) @(negedge mclk);
        chkBit(doutOeN, 1'b1);
        peek(8'h12, 16'ha5c3);
    endtask
    task automatic s_badcount();
        frame(wr(8'h40, 16'h1234) >> 1, 26, 0);
        frame((wr(8'h40, 16'h1234) << 1) | 128'h1, 28, 0);
        // the unused opcode must never reach the array, whatever follows
        frame({101'h0, 1'b1, 2'h2, EXT_FILL_ALL, 6'h00, 16'h1234},
              27, 0);
        peek(8'h40, 16'hffff);
    endtask
    task automatic s_ignore();
        u_master.send(wr(8'h30, 16'h0f0f), 27);
        frame(wr(8'h31, 16'hf0f0), 27, 1);
        peek(8'h30, 16'h0f0f);
        peek(8'h31, 16'hffff);
    endtask
    task automatic s_page();
        frame({85'h0, 1'b1, OP_PAGE_WRITE, 8'h07, 16'h1111, 16'h2222},
              43, 1);
        peek(8'h07, 16'h1111);
        peek(8'h04, 16'h2222);
        peek(8'h08, 16'hffff);
        frame({93'h0, 1'b1, OP_PAGE_WRITE, 8'h20, 16'h3333, 8'h44},
              35, 0);
        peek(8'h20, 16'hffff);
    endtask
    task automatic s_protect();
        frame({109'h0, 1'b1, OP_EXT, EXT_PROT_WR, 6'h00, 8'h80},
              19, -1);
        frame(wr(8'h90, 16'h5555), 27, 1);
        peek(8'h90, 16'hffff);
        frame(wr(8'h10, 16'h6666), 27, 1);
        peek(8'h10, 16'h6666);
        frame(fill(16'h7777), 27, 1);
        peek(8'h10, 16'h6666);
        frame({117'h0, 1'b1, OP_EXT, EXT_PROT_CLR, 6'h00},
              11, -1);
        frame(fill(16'hbeef), 27, 1);
        peek(8'h00, 16'hbeef);
        peek(8'hff, 16'hbeef);
    endtask
    initial begin
        failures = 0;
        cmpCount = 0;
        cycles = 0;
        rst = 1'b1;
        ce = 1'b1;
        peekAddr = 8'h00;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        repeat (4) @(posedge mclk);
        peek(8'h00, ERASED_WORD);
        peek(8'hff, ERASED_WORD);
        s_status();
        s_badcount();
        s_ignore();
        s_page();
        s_protect();
        stop_test();
    end
endmodule
`default_nettype wire
